// *** i2ctm_regs.svh ***
// register map, field positions, reset values and timing counts of the i2c clock and time-out monitor
// assumes a 32-bit apb slave with one register per aligned word
`ifndef I2CTM_REGS_SVH
`define I2CTM_REGS_SVH
`define I2CTM_ADDR_CTRL1   12'h000
`define I2CTM_ADDR_CTRL2   12'h004
`define I2CTM_ADDR_PCLK    12'h008
`define I2CTM_ADDR_MODE    12'h00c
`define I2CTM_C1_MON_SDA   4
`define I2CTM_C1_MON_SCL   5
`define I2CTM_C1_CK0       6
`define I2CTM_C1_CK1       7
`define I2CTM_C2_TO_EN     0
`define I2CTM_C2_TO_FLAG   1
`define I2CTM_C2_TO_PERIOD 2
`define I2CTM_C2_CKLO      3
`define I2CTM_C2_CKHI      5
`define I2CTM_C2_SCP       7
`define I2CTM_PC_SRC       0
`define I2CTM_MD_EN        0
`define I2CTM_MD_STOPW     1
`define I2CTM_MD_WAIT      2
`define I2CTM_MD_STOP      3
`define I2CTM_MD_LOWP      4
`define I2CTM_RESET_BYTE   8'h00
`define I2CTM_TO_LONG_MAX  16'hffff
`define I2CTM_TO_SHORT_MAX 16'h3fff
`define I2CTM_DIV_W        4
`endif

// *** i2ctm_pkg.sv ***
// types shared by the i2c clock and time-out monitor files
// assumes i2ctm_regs.svh is on the include path
package i2ctm_pkg;
  typedef enum logic [2:0] {I2CTM_DIV2, I2CTM_DIV4, I2CTM_DIV8, I2CTM_DIV25,
                            I2CTM_DIV3, I2CTM_DIV5, I2CTM_DIV6, I2CTM_DIVX} i2ctm_div_e;
  typedef struct packed {
    logic sda;
    logic scl;
  } i2ctm_lines_s;
  typedef struct packed {
    logic       paddr_ok;
    logic [7:0] wbyte;
  } i2ctm_wr_s;
endpackage

// *** i2ctm_clkdiv.sv ***
// fractional divider that makes a one-cycle system clock enable from the source enable
// assumes src_tick marks each source clock period on pclk
`include "i2ctm_regs.svh"
`timescale 1ns/1ps
module i2ctm_clkdiv
  import i2ctm_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // control
  input  wire logic              run,
  input  wire logic              src_tick,
  input  i2ctm_pkg::i2ctm_div_e  ratio,
  // output
  output logic                   sys_tick
);
  logic [`I2CTM_DIV_W-1:0] cnt;
  logic [`I2CTM_DIV_W-1:0] half_cnt;
  logic [`I2CTM_DIV_W-1:0] limit;
  logic                    wrap;
  // terminal count is the ratio minus one; 2.5 is made as 5 source ticks per two outputs
  assign limit = (ratio == I2CTM_DIV2)  ? 4'h1 :
                 (ratio == I2CTM_DIV4)  ? 4'h3 :
                 (ratio == I2CTM_DIV8)  ? 4'h7 :
                 (ratio == I2CTM_DIV25) ? 4'h4 :
                 (ratio == I2CTM_DIV3)  ? 4'h2 :
                 (ratio == I2CTM_DIV5)  ? 4'h4 :
                 (ratio == I2CTM_DIV6)  ? 4'h5 : 4'h1;
  assign half_cnt = 4'h2;
  assign wrap = src_tick && (cnt >= limit);
  // count source ticks and emit one system tick per wrap, two per wrap for 2.5
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt      <= 4'h0;
      sys_tick <= 1'b0;
    end
    else
    begin
      sys_tick <= 1'b0;
      if (!run)
        cnt <= 4'h0;
      else if (src_tick)
      begin
        cnt <= wrap ? 4'h0 : cnt + 4'h1;
        sys_tick <= wrap || ((ratio == I2CTM_DIV25) && (cnt == half_cnt));
      end
    end
  end
endmodule

// *** i2ctm_top.sv ***
// i2c clock select, line monitor, time-out detector and stop request bit behind apb
// assumes sda/scl pins and bus busy / stop detect come from the byte engine; pins are asynchronous
//
// Design decisions made here: the register addresses and register access over APB.
`include "i2ctm_regs.svh"
`timescale 1ns/1ps
module i2ctm_top
  import i2ctm_pkg::*;
(
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // i2c engine side
  input  i2ctm_pkg::i2ctm_lines_s drive_lines,
  input  wire logic               scl_pin,
  input  wire logic               bus_busy_flag,
  input  wire logic               stop_detected,
  // results
  output logic                    sys_tick,
  output logic                    iface_irq,
  output logic                    iface_active
);
  import i2ctm_pkg::*;

  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic       src_sel;
  logic [4:0] mode;
  logic [15:0] to_cnt;
  logic       half_tgl;
  logic       scl_s1;
  logic       scl_s2;
  logic       busy_s1;
  logic       busy_s2;
  logic       tick_raw;
  i2ctm_lines_s mon;

  // decode of the bus request
  wire        acc     = psel && penable;
  wire        wr      = acc && pwrite;
  wire        hit_c1  = (paddr == `I2CTM_ADDR_CTRL1);
  wire        hit_c2  = (paddr == `I2CTM_ADDR_CTRL2);
  wire        hit_pc  = (paddr == `I2CTM_ADDR_PCLK);
  wire        hit_md  = (paddr == `I2CTM_ADDR_MODE);
  wire        hit_any = hit_c1 || hit_c2 || hit_pc || hit_md;
  wire [7:0]  wb      = pwdata[7:0];

  // clock availability: wait keeps it unless stopped, stop and low power remove it
  wire clk_ok = mode[`I2CTM_MD_EN] && !mode[`I2CTM_MD_STOP] && !mode[`I2CTM_MD_LOWP]
              && !(mode[`I2CTM_MD_WAIT] && mode[`I2CTM_MD_STOPW]);

  // five-bit select joined from both registers
  wire [4:0] div_sel = {ctrl2[`I2CTM_C2_CKHI:`I2CTM_C2_CKLO],
                        ctrl1[`I2CTM_C1_CK1], ctrl1[`I2CTM_C1_CK0]};

  function automatic i2ctm_div_e decode_div(input logic [4:0] s);
    i2ctm_div_e r;
    r = I2CTM_DIVX;
    unique case (s[4:2])
      3'b000:  r = (s[1:0] == 2'b00) ? I2CTM_DIV2 : (s[1:0] == 2'b01) ? I2CTM_DIV4 : I2CTM_DIV8;
      3'b001:  r = I2CTM_DIV25;
      3'b010:  r = I2CTM_DIV3;
      3'b011:  r = I2CTM_DIV5;
      3'b100:  r = I2CTM_DIV6;
      default: r = I2CTM_DIV2;  // forbidden codes: fall back to the fastest ratio
    endcase
    return r;
  endfunction

  wire i2ctm_div_e ratio = decode_div(div_sel);

  // f1 ticks every pclk, f2 every second pclk
  wire src_tick = src_sel ? half_tgl : 1'b1;

  i2ctm_clkdiv u_div
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (clk_ok),
    .src_tick (src_tick),
    .ratio    (ratio),
    .sys_tick (tick_raw)
  );

  // time-out counting condition and terminal count
  wire       to_en    = ctrl2[`I2CTM_C2_TO_EN] && mode[`I2CTM_MD_EN];
  wire       to_arm   = to_en && busy_s2 && scl_s2;
  wire [15:0] to_max  = ctrl2[`I2CTM_C2_TO_PERIOD] ? `I2CTM_TO_SHORT_MAX : `I2CTM_TO_LONG_MAX;
  wire       to_ovf   = to_arm && tick_raw && (to_cnt >= to_max);
  wire       stop_ev  = stop_detected && mode[`I2CTM_MD_EN] && clk_ok;

  // register read mux; monitor bits come from the driven levels
  wire [7:0] rd_c1 = {ctrl1[7:6], mon.scl, mon.sda, 4'h0};
  wire [7:0] rd_byte = hit_c1 ? rd_c1 : hit_c2 ? ctrl2 : hit_pc ? {7'h0, src_sel} :
                       hit_md ? {3'h0, mode} : 8'h00;

  // synchronisers for pins and toggle for f2
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_s1   <= 1'b1;
      scl_s2   <= 1'b1;
      busy_s1  <= 1'b0;
      busy_s2  <= 1'b0;
      half_tgl <= 1'b0;
      mon      <= '0;
    end
    else
    begin
      scl_s1   <= scl_pin;
      scl_s2   <= scl_s1;
      busy_s1  <= bus_busy_flag;
      busy_s2  <= busy_s1;
      half_tgl <= !half_tgl;
      mon      <= drive_lines;
    end
  end

  // software registers; monitor bits ignore writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl1   <= `I2CTM_RESET_BYTE;
      src_sel <= 1'b0;
      mode    <= 5'h00;
    end
    else if (wr)
    begin
      if (hit_c1)
        ctrl1 <= {wb[7:6], 6'h00};
      if (hit_pc)
        src_sel <= wb[`I2CTM_PC_SRC];
      if (hit_md)
        mode <= wb[4:0];
    end
  end

  // control two: flags set by hardware win over software clears
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl2 <= `I2CTM_RESET_BYTE;
    else
    begin
      if (wr && hit_c2)
      begin
        ctrl2[`I2CTM_C2_TO_EN]     <= wb[`I2CTM_C2_TO_EN];
        ctrl2[`I2CTM_C2_TO_PERIOD] <= wb[`I2CTM_C2_TO_PERIOD];
        ctrl2[`I2CTM_C2_CKHI:`I2CTM_C2_CKLO] <= wb[`I2CTM_C2_CKHI:`I2CTM_C2_CKLO];
        ctrl2[`I2CTM_C2_TO_FLAG]   <= ctrl2[`I2CTM_C2_TO_FLAG] && wb[`I2CTM_C2_TO_FLAG];
        ctrl2[`I2CTM_C2_SCP]   <= ctrl2[`I2CTM_C2_SCP] && wb[`I2CTM_C2_SCP];
      end
      if (to_ovf)
        ctrl2[`I2CTM_C2_TO_FLAG] <= 1'b1;
      if (stop_ev)
        ctrl2[`I2CTM_C2_SCP] <= 1'b1;
    end
  end

  // time-out counter on system ticks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      to_cnt <= 16'h0000;
    else if (!to_arm)
      to_cnt <= 16'h0000;
    else if (to_cnt > to_max)
      to_cnt <= 16'h0000;                                                             // long count left over after a switch to short
    else if (tick_raw)
      to_cnt <= (to_cnt >= to_max) ? 16'h0000 : to_cnt + 16'h0001;
  end

  // registered outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata       <= 32'h0000_0000;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      sys_tick     <= 1'b0;
      iface_irq    <= 1'b0;
      iface_active <= 1'b0;
    end
    else
    begin
      pready       <= psel && !penable;
      pslverr      <= psel && !penable && !hit_any;
      prdata       <= {24'h000000, rd_byte};
      sys_tick     <= tick_raw;
      iface_irq    <= to_ovf || stop_ev;
      iface_active <= clk_ok;
    end
  end

  AST_OVF_SETS_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    to_ovf |=> ctrl2[`I2CTM_C2_TO_FLAG] && iface_irq)
    else $error("time-out flag or irq missing after overflow");
  AST_SCL_LOW_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    !scl_s2 |=> to_cnt == 16'h0000)
    else $error("counter not cleared with scl low");
  AST_NO_COUNT_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    (!busy_s2 || !to_en) |=> to_cnt == 16'h0000)
    else $error("counter ran without busy bus and enable");
  AST_SHORT_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl2[`I2CTM_C2_TO_PERIOD] && $stable(ctrl2) |-> to_cnt <= `I2CTM_TO_SHORT_MAX)
    else $error("short mode counter above 14 bits");
  AST_SCP_WRITE_ONE: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl2[`I2CTM_C2_SCP] && !stop_ev && wr && hit_c2 |=> !ctrl2[`I2CTM_C2_SCP])
    else $error("writing one set stop request");
  AST_STOP_SETS: assert property (@(posedge pclk) disable iff (!presetn)
    stop_ev |=> ctrl2[`I2CTM_C2_SCP] && iface_irq)
    else $error("stop detect did not set request");
  AST_MON_RO: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 rd_c1[`I2CTM_C1_MON_SDA] == $past(drive_lines.sda))
    else $error("sda monitor wrong");
  AST_NO_CLK_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    (mode[`I2CTM_MD_STOP] || mode[`I2CTM_MD_LOWP]) ##1 (mode[`I2CTM_MD_STOP] || mode[`I2CTM_MD_LOWP])
    |-> !tick_raw)
    else $error("system tick in stop or low power");
endmodule

// *** i2ctm_bus_model.sv ***
// far side of the i2c bus: other masters and slaves that hold scl, keep the bus busy and end frames
// assumes the bench calls its tasks; every change lands just after a rising pclk edge
`timescale 1ns/1ps
module i2ctm_bus_model
(
  // clock
  input  wire logic pclk,
  // bus levels seen by the interface
  output logic      scl_pin,
  output logic      bus_busy_flag,
  output logic      stop_detected
);
  // idle bus: scl pulled up, nobody holding it
  initial
  begin
    scl_pin = 1'b1;
    bus_busy_flag = 1'b0;
    stop_detected = 1'b0;
  end
  // drive the busy flag and scl to the given levels; a stalled transfer is busy with scl left high
  task set_bus(input logic busy, input logic scl);
    @(posedge pclk);
    bus_busy_flag <= busy;
    scl_pin <= scl;
  endtask
  // one-cycle report of a stop condition
  task stop_pulse();
    @(posedge pclk);
    stop_detected <= 1'b1;
    @(posedge pclk);
    stop_detected <= 1'b0;
  endtask
endmodule

// *** testbench.sv ***
// self-checking bench for the clock select, line monitor, time-out and stop request logic
// assumes i2ctm_pkg, i2ctm_regs.svh and i2ctm_bus_model are compiled first
`include "i2ctm_regs.svh"
`timescale 1ns/1ps
module testbench;
  import i2ctm_pkg::*;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0, prdata, rd;
  logic         pready, pslverr, er, sys_tick, iface_irq, iface_active;
  logic         scl_pin, bus_busy_flag, stop_detected;
  i2ctm_lines_s drive_lines = 2'h0;
  int           failures = 0, checks = 0;
  // design and the far bus
  i2ctm_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drive_lines(drive_lines), .scl_pin(scl_pin), .bus_busy_flag(bus_busy_flag),
    .stop_detected(stop_detected), .sys_tick(sys_tick), .iface_irq(iface_irq), .iface_active(iface_active));
  i2ctm_bus_model mdl (.pclk(pclk), .scl_pin(scl_pin), .bus_busy_flag(bus_busy_flag), .stop_detected(stop_detected));
  always #5 pclk = ~pclk;
  // compare, report and count
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge pclk);
    end
    if (n == 50)
      failures++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask
  // cycles taken by four system clock ticks
  task period(output int n);
    int k;
    n = 0;
    k = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (sys_tick !== 1'b1 && n < 100);
    n = 0;
    while (k < 4 && n < 400)
    begin
      @(posedge pclk);
      n++;
      if (sys_tick === 1'b1)
        k++;
    end
  endtask
  // reset values and an unmapped address
  task t_reset();
    for (int i = 0; i < 4; i++)
      rchk(12'(i * 4), {24'h0, `I2CTM_RESET_BYTE}, "reset value");
    chk("active after reset", iface_active, 1'b0);
    apb(1'b0, 12'h010, 32'hffffffff);
    chk("unmapped err", er, 1'b1);
    chk("unmapped data", rd, 32'h0);
    $display("test reset done");
  endtask
  // monitor bits follow the driven levels and ignore writes
  task t_monitor();
    @(posedge pclk);
    drive_lines <= 2'b10;
    apb(1'b1, `I2CTM_ADDR_CTRL1, 32'h70);
    rchk(`I2CTM_ADDR_CTRL1, 32'h50, "ctrl1 sda high");
    @(posedge pclk);
    drive_lines <= 2'b01;
    apb(1'b1, `I2CTM_ADDR_CTRL1, 32'h00);
    rchk(`I2CTM_ADDR_CTRL1, 32'h20, "ctrl1 scl high");
    $display("test monitor done");
  endtask
  // every listed divide code from both source clocks
  task t_div();
    logic [4:0] code [7] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h0c, 5'h10};
    int         cyc [7] = '{8, 16, 32, 10, 12, 20, 24};
    int         n;
    apb(1'b1, `I2CTM_ADDR_MODE, 32'h01);
    for (int s = 0; s < 2; s++)
      for (int i = 0; i < 7; i++)
      begin
        apb(1'b1, `I2CTM_ADDR_PCLK, 32'(s));
        apb(1'b1, `I2CTM_ADDR_CTRL1, {24'h0, code[i][1:0], 6'h0});
        apb(1'b1, `I2CTM_ADDR_CTRL2, {26'h0, code[i][4:2], 3'h0});
        period(n);
        period(n);
        chk("four ticks", n, cyc[i] * (s + 1));
      end
    apb(1'b1, `I2CTM_ADDR_PCLK, 32'h0);
    apb(1'b1, `I2CTM_ADDR_CTRL1, 32'h0);
    apb(1'b1, `I2CTM_ADDR_CTRL2, 32'h0);
    $display("test divider done");
  endtask
  // wait, stop and low-power modes
  task t_modes();
    logic [7:0] md [5] = '{8'h01, 8'h05, 8'h07, 8'h09, 8'h11};
    logic       ex [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    int         k;
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, `I2CTM_ADDR_MODE, {24'h0, md[i]});
      repeat (3) @(posedge pclk);
      k = 0;
      repeat (40)
      begin
        @(posedge pclk);
        if (sys_tick === 1'b1)
          k++;
      end
      chk("clock supplied", iface_active, ex[i]);
      chk("ticks seen", k > 0, ex[i]);
    end
    apb(1'b1, `I2CTM_ADDR_MODE, 32'h01);
    $display("test modes done");
  endtask
  // stop event sets the request bit; only a zero write clears it
  task t_stop();
    logic seen;
    seen = 1'b0;
    mdl.stop_pulse();
    repeat (5)
    begin
      @(posedge pclk);
      if (iface_irq === 1'b1)
        seen = 1'b1;
    end
    chk("stop irq", seen, 1'b1);
    rchk(`I2CTM_ADDR_CTRL2, 32'h80, "stop bit set");
    apb(1'b1, `I2CTM_ADDR_CTRL2, 32'h80);
    rchk(`I2CTM_ADDR_CTRL2, 32'h80, "stop bit kept");
    apb(1'b1, `I2CTM_ADDR_CTRL2, 32'h00);
    rchk(`I2CTM_ADDR_CTRL2, 32'h00, "stop bit cleared");
    $display("test stop done");
  endtask
  // long period does not expire early; short period expires at 16384 ticks of /2
  task t_timeout();
    int n;
    logic seen;
    seen = 1'b0;
    mdl.set_bus(1'b1, 1'b0);
    apb(1'b1, `I2CTM_ADDR_CTRL2, 32'h01);
    mdl.set_bus(1'b1, 1'b1);
    repeat (33000)
    begin
      @(posedge pclk);
      if (iface_irq === 1'b1)
        seen = 1'b1;
    end
    chk("long not expired", seen, 1'b0);
    mdl.set_bus(1'b1, 1'b0);
    repeat (6) @(posedge pclk);
    apb(1'b1, `I2CTM_ADDR_CTRL2, 32'h05);
    mdl.set_bus(1'b1, 1'b1);
    n = 0;
    while (iface_irq !== 1'b1 && n < 40000)
    begin
      @(posedge pclk);
      n++;
    end
    chk("short expiry time", n > 32760 && n < 32800, 1'b1);
    rchk(`I2CTM_ADDR_CTRL2, 32'h07, "flag set");
    apb(1'b1, `I2CTM_ADDR_MODE, 32'h00);
    apb(1'b1, `I2CTM_ADDR_CTRL2, 32'h00);
    rchk(`I2CTM_ADDR_CTRL2, 32'h00, "flag cleared");
    mdl.set_bus(1'b0, 1'b1);
    $display("test timeout done");
  endtask
  // verdict and end of run
  task end_sim();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial
  begin
    #900000;
    failures++;
    end_sim();
  end
  // main sequence
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_monitor();
    t_div();
    t_modes();
    t_stop();
    t_timeout();
    end_sim();
  end
endmodule
